// *** shaf_pkg.sv ***
/*
  shared constants and carrier types for the show-ahead fifo with level flags.
  assumes a single clock domain and an ahb-lite register port with 32-bit data.
*/
package shaf_pkg;

  // ****************************************
  // datapath defaults
  // ****************************************
  localparam int WORD_WIDTH = 16;
  localparam int CAPACITY = 4;
  localparam int LOW_LEVEL_LIMIT = 1;
  localparam int HIGH_LEVEL_LIMIT = 3;
  localparam int HEAD_LATENCY = 3;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_BITS = 12;
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] CONFIG_OFFSET = 12'h008;

  localparam int CTRL_FLUSH_BIT = 0;
  localparam int CTRL_BLOCK_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  localparam int STATUS_COUNT_LSB = 0;
  localparam int STATUS_COUNT_BITS = 8;
  localparam int STATUS_HEAD_OK_BIT = 8;
  localparam int STATUS_LEVEL_BIT = 9;
  localparam int STATUS_HIGH_BIT = 10;
  localparam int STATUS_DROP_FULL_BIT = 16;
  localparam int STATUS_DROP_EMPTY_BIT = 17;

  localparam int CONFIG_CAP_LSB = 0;
  localparam int CONFIG_LOW_LSB = 8;
  localparam int CONFIG_HIGH_LSB = 16;
  localparam int CONFIG_FIELD_BITS = 8;

  // ****************************************
  // ahb-lite codes
  // ****************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic valid;
  } shaf_bus_req_s;

  typedef struct packed {
    logic drop_empty;
    logic drop_full;
  } shaf_sticky_s;

endpackage

// *** shaf_fifo.sv ***
/*
  storage fifo of parameterised width and depth with valid/ready on both sides.
  assumes one clock, asynchronous active-low reset, flush clears all entries.
*/
`timescale 1ns/1ns
module shaf_fifo #(
  parameter int WIDTH = shaf_pkg::WORD_WIDTH,
  parameter int DEPTH = shaf_pkg::CAPACITY
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic do_write;
  logic do_read;

  // ****************************************
  // handshake
  // ****************************************
  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign do_write = in_valid && in_ready && !flush;
  assign do_read = out_valid && out_ready && !flush;

  // ****************************************
  // storage
  // ****************************************
  always_ff @(posedge clk) begin
    if (do_write) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_write) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_read) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(do_write) - (PW+1)'(do_read);
    end
  end

endmodule

// *** shaf_top.sv ***
/*
  show-ahead fifo with low and high level flags and an ahb-lite register port.
  assumes writer and reader logic on the same clock; registers at byte offsets
  0x000, 0x004, 0x008; zero wait state slave, always okay.
*/
// Overview of operation
// - a cycle with push_enable high stores push_value unless the buffer is full, writes are blocked or a flush is on.
// - head word with head_ok holds steady until pop_ack.
// - pop_ack discards the head and shows the next stored word.
// - head_word means something only while head_ok is high.
// - capacity, low limit and high limit are non-zero static parameters.
// - capacity bounds how many words are stored at once.
// - level_high_mark is one while count exceeds the low limit.
// - occupancy_high is one while count exceeds the high limit.
// - write to head_ok three cycles; write or pop to flags one cycle.
// - words may be wide; head_ok and the flags stay single bits.
`timescale 1ns/1ns
module shaf_top #(
  parameter int WORD_WIDTH = shaf_pkg::WORD_WIDTH,
  parameter int CAPACITY = shaf_pkg::CAPACITY,
  parameter int LOW_LEVEL_LIMIT = shaf_pkg::LOW_LEVEL_LIMIT,
  parameter int HIGH_LEVEL_LIMIT = shaf_pkg::HIGH_LEVEL_LIMIT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic push_enable,
  input wire logic [WORD_WIDTH-1:0] push_value,
  input wire logic pop_ack,
  output logic [WORD_WIDTH-1:0] head_word,
  output logic head_ok,
  output logic level_high_mark,
  output logic occupancy_high
);

  // ****************************************
  // static checks on the setup
  // ****************************************
  localparam int CW = $clog2(CAPACITY + 1);

  if (CAPACITY < 1) begin : g_bad_capacity
    $error("capacity must be non-zero");
  end
  if (LOW_LEVEL_LIMIT < 1) begin : g_bad_low
    $error("low level limit must be non-zero");
  end
  if (HIGH_LEVEL_LIMIT < 1) begin : g_bad_high
    $error("high level limit must be non-zero");
  end
  // count and config fields are eight bits wide
  if (CAPACITY >= (1 << shaf_pkg::CONFIG_FIELD_BITS) || LOW_LEVEL_LIMIT >= (1 << shaf_pkg::CONFIG_FIELD_BITS)
      || HIGH_LEVEL_LIMIT >= (1 << shaf_pkg::CONFIG_FIELD_BITS)) begin : g_bad_field
    $error("setup values must fit the register fields");
  end
  if (WORD_WIDTH < 1) begin : g_bad_width
    $error("word width must be non-zero");
  end

  // ****************************************
  // declarations
  // ****************************************
  shaf_pkg::shaf_bus_req_s bus_req;
  shaf_pkg::shaf_sticky_s sticky;
  logic flush_pulse;
  logic write_block;
  logic [CW-1:0] occ;
  logic [CW-1:0] next_occ;
  logic accept;
  logic pop_take;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [WORD_WIDTH-1:0] fifo_out_data;
  logic [WORD_WIDTH-1:0] stage_word;
  logic stage_ok;
  logic stage_to_head;
  logic fifo_to_stage;
  logic addr_phase;
  logic bus_write;
  logic ctrl_write;
  logic status_write;
  logic [31:0] next_rdata;
  logic [31:0] status_word;
  logic [31:0] config_word;

  // ****************************************
  // write side acceptance
  // ****************************************
  // refuse when full so stored words are never overwritten
  assign accept = push_enable && !flush_pulse && !write_block
    && (occ != CW'(CAPACITY)) && fifo_in_ready;

  // a pop with no head is dropped
  assign pop_take = pop_ack && head_ok && !flush_pulse;

  // ****************************************
  // storage buffer
  // ****************************************
  shaf_fifo #(
    .WIDTH(WORD_WIDTH),
    .DEPTH(CAPACITY)
  ) u_store (
    .clk(hclk),
    .rst_n(hresetn),
    .flush(flush_pulse),
    .in_valid(accept),
    .in_ready(fifo_in_ready),
    .in_data(push_value),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ****************************************
  // show-ahead pipeline: store, stage, head
  // ****************************************
  assign stage_to_head = stage_ok && (!head_ok || pop_take);
  assign fifo_out_ready = !stage_ok || stage_to_head;
  assign fifo_to_stage = fifo_out_valid && fifo_out_ready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_ok <= 1'b0;
    end else if (flush_pulse) begin
      stage_ok <= 1'b0;
    end else if (fifo_to_stage) begin
      stage_ok <= 1'b1;
    end else if (stage_to_head) begin
      stage_ok <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_word <= '0;
    end else if (fifo_to_stage) begin
      stage_word <= fifo_out_data;
    end
  end

  // head holds until popped; second pipe stage gives three cycle latency
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      head_ok <= 1'b0;
    end else if (flush_pulse) begin
      head_ok <= 1'b0;
    end else if (stage_to_head) begin
      head_ok <= 1'b1;
    end else if (pop_take) begin
      head_ok <= 1'b0;
    end
  end

  // head_word changes only when a new word is shown
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      head_word <= '0;
    end else if (stage_to_head) begin
      head_word <= stage_word;
    end
  end

  // ****************************************
  // occupancy and level flags
  // ****************************************
  always_comb begin
    next_occ = occ;
    if (accept && !pop_take) begin
      next_occ = occ + CW'(1);
    end else if (pop_take && !accept) begin
      next_occ = occ - CW'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      occ <= '0;
    end else if (flush_pulse) begin
      occ <= '0;
    end else begin
      occ <= next_occ;
    end
  end

  // flags follow the count one cycle after a push or pop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_high_mark <= 1'b0;
    end else if (flush_pulse) begin
      level_high_mark <= 1'b0;
    end else begin
      level_high_mark <= (int'(next_occ) > LOW_LEVEL_LIMIT);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      occupancy_high <= 1'b0;
    end else if (flush_pulse) begin
      occupancy_high <= 1'b0;
    end else begin
      occupancy_high <= (int'(next_occ) > HIGH_LEVEL_LIMIT);
    end
  end

  // ****************************************
  // sticky refusal flags
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sticky <= '0;
    end else begin
      if (push_enable && !accept) begin
        sticky.drop_full <= 1'b1;
      end else if (status_write && hwdata[shaf_pkg::STATUS_DROP_FULL_BIT]) begin
        sticky.drop_full <= 1'b0;
      end
      if (pop_ack && !head_ok) begin
        sticky.drop_empty <= 1'b1;
      end else if (status_write && hwdata[shaf_pkg::STATUS_DROP_EMPTY_BIT]) begin
        sticky.drop_empty <= 1'b0;
      end
    end
  end

  // ****************************************
  // ahb-lite address and data phase
  // ****************************************
  assign addr_phase = hsel && hready && (htrans == shaf_pkg::HTRANS_NONSEQ || htrans == 2'h3);
  assign bus_write = bus_req.valid && bus_req.write;
  assign ctrl_write = bus_write && (bus_req.addr == shaf_pkg::CTRL_OFFSET);
  assign status_write = bus_write && (bus_req.addr == shaf_pkg::STATUS_OFFSET);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_req <= '0;
    end else if (hready) begin
      bus_req.valid <= addr_phase;
      bus_req.write <= hwrite;
      bus_req.addr <= haddr[shaf_pkg::ADDR_BITS-1:0];
    end
  end

  // zero wait states, every answer okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= shaf_pkg::HRESP_OKAY;
    end else begin
      hresp <= shaf_pkg::HRESP_OKAY;
    end
  end

  // ****************************************
  // control register
  // ****************************************
  // flush is a one-cycle pulse after the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flush_pulse <= shaf_pkg::CTRL_RESET[shaf_pkg::CTRL_FLUSH_BIT];
    end else begin
      flush_pulse <= ctrl_write && hwdata[shaf_pkg::CTRL_FLUSH_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_block <= shaf_pkg::CTRL_RESET[shaf_pkg::CTRL_BLOCK_BIT];
    end else if (ctrl_write) begin
      write_block <= hwdata[shaf_pkg::CTRL_BLOCK_BIT];
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    status_word = '0;
    status_word[shaf_pkg::STATUS_COUNT_LSB +: shaf_pkg::STATUS_COUNT_BITS] =
      shaf_pkg::STATUS_COUNT_BITS'(occ);
    status_word[shaf_pkg::STATUS_HEAD_OK_BIT] = head_ok;
    status_word[shaf_pkg::STATUS_LEVEL_BIT] = level_high_mark;
    status_word[shaf_pkg::STATUS_HIGH_BIT] = occupancy_high;
    status_word[shaf_pkg::STATUS_DROP_FULL_BIT] = sticky.drop_full;
    status_word[shaf_pkg::STATUS_DROP_EMPTY_BIT] = sticky.drop_empty;
  end

  always_comb begin
    config_word = '0;
    config_word[shaf_pkg::CONFIG_CAP_LSB +: shaf_pkg::CONFIG_FIELD_BITS] =
      shaf_pkg::CONFIG_FIELD_BITS'(CAPACITY);
    config_word[shaf_pkg::CONFIG_LOW_LSB +: shaf_pkg::CONFIG_FIELD_BITS] =
      shaf_pkg::CONFIG_FIELD_BITS'(LOW_LEVEL_LIMIT);
    config_word[shaf_pkg::CONFIG_HIGH_LSB +: shaf_pkg::CONFIG_FIELD_BITS] =
      shaf_pkg::CONFIG_FIELD_BITS'(HIGH_LEVEL_LIMIT);
  end

  always_comb begin
    next_rdata = '0;
    unique case (haddr[shaf_pkg::ADDR_BITS-1:0])
      shaf_pkg::CTRL_OFFSET: begin
        next_rdata[shaf_pkg::CTRL_BLOCK_BIT] = write_block;
      end
      shaf_pkg::STATUS_OFFSET: begin
        next_rdata = status_word;
      end
      shaf_pkg::CONFIG_OFFSET: begin
        next_rdata = config_word;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // read data sampled at the address phase, shown in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (addr_phase && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

endmodule

// *** shaf_reader.sv ***
/*
  reader side model: acknowledges the head word and records what it takes.
  assumes the fifo's registered head_ok and head_word on the same clock.
*/
`timescale 1ns/1ns
module shaf_reader #(
  parameter int WIDTH = shaf_pkg::WORD_WIDTH
) (
  input wire logic hclk,
  input wire logic go,
  input wire logic force_pop,
  input wire logic head_ok,
  input wire logic [WIDTH-1:0] head_word,
  output logic pop_ack
);
  logic [WIDTH-1:0] seen[$];
  // pops only while the head is valid unless told to misbehave
  assign pop_ack = force_pop | (go & head_ok);
  // word is only meaningful with head_ok
  always @(posedge hclk) begin
    if (pop_ack && head_ok) begin
      seen.push_back(head_word);
    end
  end
endmodule

// *** shaf_properties.sv ***
/*
  checker for the fifo data ports and level flags.
  assumes it is bound to shaf_top and sees only its ports.
*/
`timescale 1ns/1ns
module shaf_properties #(
  parameter int WORD_WIDTH = 16,
  parameter int CAPACITY = 4,
  parameter int LOW_LEVEL_LIMIT = 1,
  parameter int HIGH_LEVEL_LIMIT = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic push_enable,
  input wire logic pop_ack,
  input wire logic [WORD_WIDTH-1:0] head_word,
  input wire logic head_ok,
  input wire logic level_high_mark,
  input wire logic occupancy_high
);
  logic [7:0] cnt;
  logic ctrl_wr_q;
  logic block_q;
  logic flush_q;
  // ****************************************
  // control register model
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_wr_q <= 1'b0;
      block_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      if (hready) begin
        ctrl_wr_q <= hsel && htrans[1] && hwrite && (haddr[11:0] == shaf_pkg::CTRL_OFFSET);
      end
      flush_q <= ctrl_wr_q && hwdata[shaf_pkg::CTRL_FLUSH_BIT];
      if (ctrl_wr_q) begin
        block_q <= hwdata[shaf_pkg::CTRL_BLOCK_BIT];
      end
    end
  end
  // ****************************************
  // reference count of stored words
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 8'h00;
    end else if (flush_q) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'(push_enable && !block_q && cnt < CAPACITY) - 8'(pop_ack && head_ok);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  flag_low_a: assert property (level_high_mark == (cnt > LOW_LEVEL_LIMIT))
    else $error("low level flag wrong");
  flag_high_a: assert property (occupancy_high == (cnt > HIGH_LEVEL_LIMIT))
    else $error("high level flag wrong");
  head_hold_a: assert property (head_ok && !pop_ack && !flush_q |=> head_ok && $stable(head_word))
    else $error("head word not held");
  head_lat_a: assert property (cnt == 0 && push_enable && !block_q && !flush_q |-> !head_ok [*3] ##1 head_ok)
    else $error("head valid latency wrong");
  pop_last_a: assert property (head_ok && pop_ack && cnt == 1 && !push_enable |=> !head_ok)
    else $error("head stays after last pop");
  both_keep_a: assert property (push_enable && !block_q && pop_ack && head_ok && cnt < CAPACITY
    |=> $stable(level_high_mark) && $stable(occupancy_high)) else $error("push with pop moved flags");
  full_keep_a: assert property (cnt == CAPACITY && push_enable && !pop_ack
    |=> $stable(level_high_mark) && occupancy_high) else $error("push into full buffer");
  empty_head_a: assert property (cnt == 0 |-> !head_ok)
    else $error("head valid while empty");
endmodule
bind shaf_top shaf_properties #(.WORD_WIDTH(WORD_WIDTH), .CAPACITY(CAPACITY),
  .LOW_LEVEL_LIMIT(LOW_LEVEL_LIMIT), .HIGH_LEVEL_LIMIT(HIGH_LEVEL_LIMIT)) i_shaf_properties (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .push_enable(push_enable),
  .pop_ack(pop_ack),
  .head_word(head_word),
  .head_ok(head_ok),
  .level_high_mark(level_high_mark),
  .occupancy_high(occupancy_high)
);

// *** shaf_top_tb.sv ***
/*
  self-checking bench for shaf_top with default parameters.
  assumes shaf_reader as the reader and the bench as writer and bus master.
*/
`timescale 1ns/1ns
module shaf_top_tb;
  logic hclk, hresetn, hsel, hwrite, push_enable, go, force_pop;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, pop_ack, head_ok, level_high_mark, occupancy_high;
  logic [15:0] push_value, head_word;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  shaf_top i_shaf_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .push_enable(push_enable), .push_value(push_value),
    .pop_ack(pop_ack), .head_word(head_word), .head_ok(head_ok), .level_high_mark(level_high_mark),
    .occupancy_high(occupancy_high));
  shaf_reader i_shaf_reader (.hclk(hclk), .go(go), .force_pop(force_pop), .head_ok(head_ok),
    .head_word(head_word), .pop_ack(pop_ack));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic print_verdict;
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= shaf_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic drain(input int n, input logic [15:0] base);
    int k;
    k = 0;
    go <= 1'b1;
    while (i_shaf_reader.seen.size() < n && k < 100) begin
      @(posedge hclk);
      k++;
      go <= (k % 6) < 3;
    end
    go <= 1'b0;
    check(i_shaf_reader.seen.size(), n);
    foreach (i_shaf_reader.seen[i]) check(i_shaf_reader.seen[i], base + 16'(i));
    i_shaf_reader.seen.delete();
    @(posedge hclk);
    check({head_ok, level_high_mark, occupancy_high}, 3'h0);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    xfer(1'b0, 32'h008, 32'h0);
    check(rd, 32'h0003_0104);
    check({hreadyout, hresp}, 32'h2);
    xfer(1'b0, 32'h00C, 32'h0);
    check(rd, 32'h0);
    xfer(1'b1, 32'h000, 32'h0);
    xfer(1'b0, 32'h000, 32'h0);
    check(rd, 32'h0);
  endtask
  task automatic t_fill;
    push_enable <= 1'b1;
    for (int i = 0; i <= shaf_pkg::CAPACITY; i++) begin
      push_value <= 16'hA000 + 16'(i);
      @(posedge hclk);
    end
    push_enable <= 1'b0;
    @(posedge hclk);
    check({head_ok, level_high_mark, occupancy_high}, 3'h7);
    xfer(1'b0, 32'h004, 32'h0);
    check(rd, 32'h0001_0704);
    xfer(1'b1, 32'h004, 32'h0003_0000);
    xfer(1'b0, 32'h004, 32'h0);
    check(rd, 32'h0000_0704);
    drain(4, 16'hA000);
  endtask
  task automatic t_latency;
    push_enable <= 1'b1;
    push_value <= 16'h5A00;
    @(posedge hclk);
    push_value <= 16'h5A01;
    @(posedge hclk);
    push_enable <= 1'b0;
    check(level_high_mark, 1'b0);
    @(posedge hclk);
    check(level_high_mark, 1'b1);
    check(head_ok, 1'b0);
    @(posedge hclk);
    check(head_ok, 1'b1);
    push_enable <= 1'b1;
    push_value <= 16'h5A02;
    go <= 1'b1;
    @(posedge hclk);
    push_enable <= 1'b0;
    go <= 1'b0;
    @(posedge hclk);
    check(level_high_mark, 1'b1);
    drain(3, 16'h5A00);
  endtask
  task automatic t_bad_pop;
    force_pop <= 1'b1;
    @(posedge hclk);
    force_pop <= 1'b0;
    xfer(1'b0, 32'h004, 32'h0);
    check(rd, 32'h0002_0000);
    xfer(1'b1, 32'h004, 32'h0003_0000);
  endtask
  task automatic t_ctrl;
    xfer(1'b1, 32'h000, 32'h2);
    xfer(1'b0, 32'h000, 32'h0);
    check(rd, 32'h2);
    push_enable <= 1'b1;
    push_value <= 16'hB000;
    @(posedge hclk);
    push_enable <= 1'b0;
    xfer(1'b0, 32'h004, 32'h0);
    check(rd, 32'h0001_0000);
    xfer(1'b1, 32'h000, 32'h0);
    push_enable <= 1'b1;
    @(posedge hclk);
    push_value <= 16'hB001;
    @(posedge hclk);
    push_enable <= 1'b0;
    repeat (2) @(posedge hclk);
    check({head_ok, level_high_mark, occupancy_high}, 3'h6);
    xfer(1'b1, 32'h000, 32'h1);
    @(posedge hclk);
    xfer(1'b0, 32'h004, 32'h0);
    check(rd, 32'h0001_0000);
    xfer(1'b1, 32'h004, 32'h0003_0000);
  endtask
  // ****************************************
  // clock, timeout, main sequence
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    push_enable = 1'b0;
    push_value = 16'h0;
    go = 1'b0;
    force_pop = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_fill();
    t_latency();
    t_bad_pop();
    t_ctrl();
    print_verdict();
  end
endmodule
